// >>> include/artc_defines.vh
// constants for the asynchronous real-time counter block
// Functional notes
// - 16-bit counter runs from prescaled reference
// - keeps counting in sleep, requests wake
// - reference clock chosen outside this block
// - 10-bit prescaler, ratio from control bits 2:0
// - code 000 stops the counter
// - codes 001/010/011 divide by 1/2/8
// - match request one count after equal compare
// - wrap request one count after equal top
// - wrap returns count value to zero
// - events thinned: top 0 third, 1 second
// - top two or more: every event passes
// - system writes except flag clears act only after synchronisation
// - pending flag high while writes cross domains
// - count/top/compare writes act after two edges
// - flags set next count, clear by ack/one
// - compare above top never matches
`ifndef ARTC_DEFINES_VH
`define ARTC_DEFINES_VH

// register indices, byte address is four times the index
`define ARTC_IDX_CTRL 4'h0
`define ARTC_IDX_STATUS 4'h1
`define ARTC_IDX_FLAGS 4'h3
`define ARTC_IDX_CNT 4'h8
`define ARTC_IDX_TOP 4'ha
`define ARTC_IDX_COMP 4'hc

// field layout
`define ARTC_PSC_MSB 2
`define ARTC_BIT_MATCH 1
`define ARTC_BIT_WRAP 0

// reset values
`define ARTC_CTRL_RST 3'h0
`define ARTC_TOP_RST 16'hffff
`define ARTC_CNT_RST 16'h0000
`define ARTC_COMP_RST 16'h0000

// prescaler terminal counts (ratio minus one)
`define ARTC_TC_DIV1 10'h000
`define ARTC_TC_DIV2 10'h001
`define ARTC_TC_DIV8 10'h007
`define ARTC_TC_DIV16 10'h00f
`define ARTC_TC_DIV64 10'h03f
`define ARTC_TC_DIV256 10'h0ff
`define ARTC_TC_DIV1024 10'h3ff

// reference edges a crossing write waits before acting
`define ARTC_SYNC_EDGES 2'h2

// event thinning ratios
`define ARTC_EVT_DIV_TOP0 2'h3
`define ARTC_EVT_DIV_TOP1 2'h2
`define ARTC_EVT_DIV_FULL 2'h1

// ahb transfer type bit that marks an active transfer
`define ARTC_HTRANS_ACTIVE 1
`endif

// >>> rtl/artc_prescaler.v
// programmable 10-bit prescaler for the reference tick
`timescale 1ns/1ps
`include "artc_defines.vh"
module artc_prescaler (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // reference edge and selection
  input wire ref_tick,
  input wire [2:0] psc_sel,
  // one-cycle count strobe
  output reg count_tick
);

  reg [9:0] div_q; // edges seen since last strobe
  reg [9:0] div_d;
  reg tick_d;

  // terminal value for each selection code
  function [9:0] term_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: term_of = `ARTC_TC_DIV1;
        3'h2: term_of = `ARTC_TC_DIV2;
        3'h3: term_of = `ARTC_TC_DIV8;
        3'h4: term_of = `ARTC_TC_DIV16;
        3'h5: term_of = `ARTC_TC_DIV64;
        3'h6: term_of = `ARTC_TC_DIV256;
        3'h7: term_of = `ARTC_TC_DIV1024;
        default: term_of = `ARTC_TC_DIV1;
      endcase
    end
  endfunction

  // divide reference edges; code zero clears the divider and gives no strobe
  always @* begin
    div_d = div_q;
    tick_d = 1'b0;
    if (psc_sel == 3'h0) begin
      div_d = 10'h000;
    end else if (ref_tick) begin
      if (div_q >= term_of(psc_sel)) begin
        div_d = 10'h000;
        tick_d = 1'b1;
      end else begin
        div_d = div_q + 10'h001;
      end
    end
  end

  // state and registered strobe
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 10'h000;
      count_tick <= 1'b0;
    end else begin
      div_q <= div_d;
      count_tick <= tick_d;
    end
  end
endmodule

// >>> rtl/artc_top.v
// real-time counter with ahb-lite register access
`timescale 1ns/1ps
`include "artc_defines.vh"
module artc_top (
  // system clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // reference clock tap, selected outside
  input wire ref_clk_in,
  // interrupt vector acknowledges
  input wire match_ack,
  input wire wrap_ack,
  // requests and events
  output reg match_irq,
  output reg wrap_irq,
  output reg match_evt,
  output reg wrap_evt
);

  // reference input synchroniser and edge detector
  reg ref_s1_q;
  reg ref_s2_q;
  reg ref_s3_q;
  wire ref_tick; // one pulse per reference rising edge

  // software-side shadow values
  reg [2:0] ctrl_sw_q; // written prescaler code
  reg [15:0] top_sw_q; // written top value
  reg [15:0] comp_sw_q; // written compare value
  reg [15:0] cnt_wr_q; // written count value
  reg cnt_wr_pend_q; // a count write is waiting

  // live values used by the counting logic
  reg [2:0] psc_q;
  reg [15:0] top_q;
  reg [15:0] comp_q;
  reg [15:0] cnt_q;

  // crossing state
  reg domain_sync_pending_q;
  reg [1:0] sync_edges_q;

  // flags raised in the count path, then synchronised
  reg match_raw_q; // toggles per match
  reg wrap_raw_q; // toggles per wrap
  reg match_s1_q;
  reg match_s2_q;
  reg match_s3_q;
  reg wrap_s1_q;
  reg wrap_s2_q;
  reg wrap_s3_q;
  reg match_flag_q;
  reg wrap_flag_q;

  // event thinning counters
  reg [1:0] match_div_q;
  reg [1:0] wrap_div_q;

  // bus state
  reg wr_pend_q; // write data phase pending
  reg rd_pend_q; // read wait state pending
  reg [3:0] idx_q; // latched register index
  reg idx_ok_q; // latched address is word-aligned and in range

  wire count_tick;
  wire addr_phase;
  wire wr_now;
  wire sync_done;
  wire match_hit;
  wire wrap_hit;
  wire match_sys;
  wire wrap_sys;
  wire clr_match;
  wire clr_wrap;

  // thinning ratio for a given top value
  function [1:0] evt_ratio;
    input [15:0] top;
    begin
      if (top == 16'h0000) begin
        evt_ratio = `ARTC_EVT_DIV_TOP0;
      end else if (top == 16'h0001) begin
        evt_ratio = `ARTC_EVT_DIV_TOP1;
      end else begin
        evt_ratio = `ARTC_EVT_DIV_FULL;
      end
    end
  endfunction

  // next thinning count after one more occurrence
  function [1:0] div_next;
    input [1:0] cur;
    input [1:0] ratio;
    begin
      if (cur + 2'h1 >= ratio) begin
        div_next = 2'h0;
      end else begin
        div_next = cur + 2'h1;
      end
    end
  endfunction

  // register read mux, reserved bits read zero
  function [31:0] rd_mux;
    input [3:0] idx;
    input ok;
    begin
      rd_mux = 32'h0000_0000;
      if (ok) begin
        case (idx)
          `ARTC_IDX_CTRL: rd_mux = {29'h0, ctrl_sw_q};
          `ARTC_IDX_STATUS: rd_mux = {31'h0, domain_sync_pending_q};
          `ARTC_IDX_FLAGS: rd_mux = {30'h0, match_flag_q, wrap_flag_q};
          `ARTC_IDX_CNT: rd_mux = {16'h0, cnt_q};
          `ARTC_IDX_TOP: rd_mux = {16'h0, top_sw_q};
          `ARTC_IDX_COMP: rd_mux = {16'h0, comp_sw_q};
          default: rd_mux = 32'h0000_0000;
        endcase
      end
    end
  endfunction

  assign ref_tick = ref_s2_q & ~ref_s3_q;
  assign addr_phase = hsel & hready & htrans[`ARTC_HTRANS_ACTIVE];
  assign wr_now = wr_pend_q & idx_ok_q;
  // the crossing completes on the second reference edge
  assign sync_done = domain_sync_pending_q & ref_tick &
    (sync_edges_q + 2'h1 == `ARTC_SYNC_EDGES);
  // compare above top can never be reached
  assign match_hit = count_tick & (cnt_q == comp_q) & (comp_q <= top_q);
  assign wrap_hit = count_tick & (cnt_q == top_q);
  assign match_sys = match_s2_q ^ match_s3_q;
  assign wrap_sys = wrap_s2_q ^ wrap_s3_q;
  // write-one clear or vector acknowledge
  assign clr_match = match_ack | (wr_now & (idx_q == `ARTC_IDX_FLAGS) & hwdata[`ARTC_BIT_MATCH]);
  assign clr_wrap = wrap_ack | (wr_now & (idx_q == `ARTC_IDX_FLAGS) & hwdata[`ARTC_BIT_WRAP]);

  // prescaler in the reference counting path
  artc_prescaler u_psc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ref_tick(ref_tick),
    .psc_sel(psc_q),
    .count_tick(count_tick)
  );

  // reference tap synchroniser; the second and third stages feed the edge detector
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_clk_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  // ahb slave: writes zero-wait, reads take one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 4'h0;
      idx_ok_q <= 1'b0;
    end else begin
      hresp <= 1'b0; // always okay
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        // data sampled after any earlier write's data phase has updated the shadows
        hrdata <= rd_mux(idx_q, idx_ok_q);
        hreadyout <= 1'b1;
        rd_pend_q <= 1'b0;
      end else if (addr_phase) begin
        idx_q <= haddr[5:2];
        idx_ok_q <= (haddr[1:0] == 2'h0) & (haddr[31:6] == 26'h0);
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  // software shadows and the crossing handshake
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_sw_q <= `ARTC_CTRL_RST;
      top_sw_q <= `ARTC_TOP_RST;
      comp_sw_q <= `ARTC_COMP_RST;
      cnt_wr_q <= `ARTC_CNT_RST;
      cnt_wr_pend_q <= 1'b0;
      domain_sync_pending_q <= 1'b0;
      sync_edges_q <= 2'h0;
    end else begin
      if (wr_now & ((idx_q == `ARTC_IDX_CTRL) | (idx_q == `ARTC_IDX_CNT) |
          (idx_q == `ARTC_IDX_TOP) | (idx_q == `ARTC_IDX_COMP))) begin
        // a new write restarts the crossing
        domain_sync_pending_q <= 1'b1;
        sync_edges_q <= 2'h0;
        case (idx_q)
          `ARTC_IDX_CTRL: ctrl_sw_q <= hwdata[`ARTC_PSC_MSB:0];
          `ARTC_IDX_CNT: begin
            cnt_wr_q <= hwdata[15:0];
            cnt_wr_pend_q <= 1'b1;
          end
          `ARTC_IDX_TOP: top_sw_q <= hwdata[15:0];
          default: comp_sw_q <= hwdata[15:0];
        endcase
      end else if (sync_done) begin
        domain_sync_pending_q <= 1'b0;
        sync_edges_q <= 2'h0;
        cnt_wr_pend_q <= 1'b0;
      end else if (domain_sync_pending_q & ref_tick) begin
        sync_edges_q <= sync_edges_q + 2'h1;
      end
    end
  end

  // live configuration and the counter itself
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_q <= `ARTC_CTRL_RST;
      top_q <= `ARTC_TOP_RST;
      comp_q <= `ARTC_COMP_RST;
      cnt_q <= `ARTC_CNT_RST;
    end else begin
      if (sync_done) begin
        psc_q <= ctrl_sw_q;
        top_q <= top_sw_q;
        comp_q <= comp_sw_q;
      end
      // a landing count write beats a count in the same cycle
      if (sync_done & cnt_wr_pend_q) begin
        cnt_q <= cnt_wr_q;
      end else if (wrap_hit) begin
        cnt_q <= 16'h0000;
      end else if (count_tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // count path raises toggles, system side sees them synchronised
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_raw_q <= 1'b0;
      wrap_raw_q <= 1'b0;
      match_s1_q <= 1'b0;
      match_s2_q <= 1'b0;
      match_s3_q <= 1'b0;
      wrap_s1_q <= 1'b0;
      wrap_s2_q <= 1'b0;
      wrap_s3_q <= 1'b0;
    end else begin
      if (match_hit) begin
        match_raw_q <= ~match_raw_q;
      end
      if (wrap_hit) begin
        wrap_raw_q <= ~wrap_raw_q;
      end
      match_s1_q <= match_raw_q;
      match_s2_q <= match_s1_q;
      match_s3_q <= match_s2_q;
      wrap_s1_q <= wrap_raw_q;
      wrap_s2_q <= wrap_s1_q;
      wrap_s3_q <= wrap_s2_q;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_flag_q <= 1'b0;
      wrap_flag_q <= 1'b0;
      match_irq <= 1'b0;
      wrap_irq <= 1'b0;
    end else begin
      match_flag_q <= match_sys | (match_flag_q & ~clr_match);
      wrap_flag_q <= wrap_sys | (wrap_flag_q & ~clr_wrap);
      // requests stay live in sleep so they can wake the core
      match_irq <= match_sys | (match_flag_q & ~clr_match);
      wrap_irq <= wrap_sys | (wrap_flag_q & ~clr_wrap);
    end
  end

  // events: thinned for tiny top values, one per occurrence otherwise
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_div_q <= 2'h0;
      wrap_div_q <= 2'h0;
      match_evt <= 1'b0;
      wrap_evt <= 1'b0;
    end else begin
      match_evt <= 1'b0;
      wrap_evt <= 1'b0;
      if (match_sys) begin
        match_div_q <= div_next(match_div_q, evt_ratio(top_q));
        match_evt <= (div_next(match_div_q, evt_ratio(top_q)) == 2'h0);
      end
      if (wrap_sys) begin
        wrap_div_q <= div_next(wrap_div_q, evt_ratio(top_q));
        wrap_evt <= (div_next(wrap_div_q, evt_ratio(top_q)) == 2'h0);
      end
    end
  end
endmodule

// >>> sim/artc_asserts.sv
// checker for the real-time counter bus and request outputs
`timescale 1ns/1ps
module artc_chk (
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // bus side
  input logic hsel,
  input logic hready,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hreadyout,
  input logic [31:0] hrdata,
  input logic hresp,
  // acks, requests, events
  input logic match_ack,
  input logic wrap_ack,
  input logic match_irq,
  input logic wrap_irq,
  input logic match_evt,
  input logic wrap_evt
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // transfer accepted at this edge
  logic take;
  assign take = hsel && hready && htrans[1];
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_go; take && hwrite |=> hreadyout; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  // read data holds until the next read ends
  property p_rd_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_mevt; match_evt |-> match_irq; endproperty
  a_mevt: assert property (p_mevt) else $error("match event without flag");
  property p_wevt; wrap_evt |-> wrap_irq; endproperty
  a_wevt: assert property (p_wevt) else $error("wrap event without flag");
  // ticks are several cycles apart, so pulses never merge
  property p_mpulse; match_evt |=> !match_evt; endproperty
  a_mpulse: assert property (p_mpulse) else $error("match event too long");
  property p_wpulse; wrap_evt |=> !wrap_evt; endproperty
  a_wpulse: assert property (p_wpulse) else $error("wrap event too long");
  property p_mack; match_ack |-> ##2 !match_irq; endproperty
  a_mack: assert property (p_mack) else $error("match ack ignored");
  property p_wack; wrap_ack |-> ##2 !wrap_irq; endproperty
  a_wack: assert property (p_wack) else $error("wrap ack ignored");
  c_rd: cover property (take && !hwrite);
  c_mevt: cover property (match_evt);
  c_wevt: cover property (wrap_evt);
endmodule
bind artc_top artc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .match_ack(match_ack), .wrap_ack(wrap_ack), .match_irq(match_irq), .wrap_irq(wrap_irq),
  .match_evt(match_evt), .wrap_evt(wrap_evt));

// >>> sim/tb_top.sv
// self-checking bench for the real-time counter
`timescale 1ns/1ps
`include "artc_defines.vh"
module tb_top;
  // bench drive
  logic hclk, hresetn, hsel, hwrite, ref_clk_in, match_ack, wrap_ack;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd;
  // design outputs
  logic hreadyout, hresp, match_irq, wrap_irq, match_evt, wrap_evt;
  logic [31:0] hrdata;
  int error_cnt, total_checks, n_mevt, n_wevt;
  // byte addresses from register indices
  localparam logic [31:0] A_CTRL = {26'h0, `ARTC_IDX_CTRL, 2'h0};
  localparam logic [31:0] A_STAT = {26'h0, `ARTC_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_FLAG = {26'h0, `ARTC_IDX_FLAGS, 2'h0};
  localparam logic [31:0] A_CNT = {26'h0, `ARTC_IDX_CNT, 2'h0};
  localparam logic [31:0] A_TOP = {26'h0, `ARTC_IDX_TOP, 2'h0};
  localparam logic [31:0] A_COMP = {26'h0, `ARTC_IDX_COMP, 2'h0};
  // single slave, so its ready is the bus ready
  artc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ref_clk_in(ref_clk_in), .match_ack(match_ack),
    .wrap_ack(wrap_ack), .match_irq(match_irq), .wrap_irq(wrap_irq), .match_evt(match_evt),
    .wrap_evt(wrap_evt));
  initial begin
    hclk = 0;
    forever #2.5 hclk = ~hclk;
  end
  // tally event pulses
  always @(posedge hclk) begin
    if (match_evt === 1'b1) n_mevt++;
    if (wrap_evt === 1'b1) n_wevt++;
  end
  task end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for ready, bounded
  task hwait;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      end_sim;
    end
  endtask
  // one single-word transfer, read data into rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hwait;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rd = hrdata;
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(0, a, 0);
    chk(rd, exp);
  endtask
  // reference edges, three cycles high and three low
  task edges(input int n);
    repeat (n) begin
      @(posedge hclk) ref_clk_in <= 1'b1;
      repeat (3) @(posedge hclk);
      ref_clk_in <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    // let the last tick reach the flags and event pulses before returning
    repeat (4) @(posedge hclk);
  endtask
  // write, then let the crossing finish before the next one
  task wrs(input logic [31:0] a, input logic [31:0] d);
    bus(1, a, d);
    edges(3);
    rdc(A_STAT, 0);
  endtask
  task t_reset;
    rdc(A_CTRL, 0);
    rdc(A_STAT, 0);
    rdc(A_FLAG, 0);
    rdc(A_CNT, 0);
    rdc(A_TOP, 32'h0000ffff);
    rdc(A_COMP, 0);
  endtask
  task t_ctrl;
    bus(1, A_CTRL, 32'h7);
    rdc(A_CTRL, 32'h7);
    rdc(A_STAT, 1);
    edges(3);
    rdc(A_STAT, 0);
    bus(1, 32'h40, 32'h5);
    rdc(32'h40, 0);
    wrs(A_CTRL, 0);
  endtask
  // each nonzero code: 2*ratio reference edges give two counts, code zero gives none
  task t_psc;
    int r[8] = '{1, 1, 2, 8, 16, 64, 256, 1024};
    logic [15:0] c0;
    for (int c = 0; c < 8; c++) begin
      bus(1, A_CTRL, c);
      edges(4);
      bus(0, A_CNT, 0);
      c0 = rd[15:0];
      edges(2 * r[c]);
      bus(0, A_CNT, 0);
      chk(rd[15:0] - c0, (c == 0) ? 0 : 2);
    end
  endtask
  task t_wrap;
    wrs(A_CTRL, 0);
    wrs(A_CNT, 0);
    wrs(A_TOP, 3);
    wrs(A_COMP, 1);
    wrs(A_CTRL, 1);
    n_mevt = 0;
    n_wevt = 0;
    edges(8);
    chk(n_wevt, 2);
    chk(n_mevt, 2);
    bus(0, A_CNT, 0);
    chk(rd[15:0], 16'h1);
    chk({match_irq, wrap_irq}, 2'h3);
    @(posedge hclk);
    match_ack <= 1'b1;
    wrap_ack <= 1'b1;
    @(posedge hclk);
    match_ack <= 1'b0;
    wrap_ack <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({match_irq, wrap_irq}, 0);
  endtask
  // thinning for small tops, compare beyond top
  task t_thin;
    wrs(A_TOP, 1);
    wrs(A_CNT, 0);
    n_mevt = 0;
    n_wevt = 0;
    edges(8);
    chk(n_wevt, 2);
    chk(n_mevt, 2);
    wrs(A_TOP, 0);
    wrs(A_CNT, 0);
    bus(1, A_FLAG, 3);
    repeat (2) @(posedge hclk);
    chk({match_irq, wrap_irq}, 0);
    n_mevt = 0;
    n_wevt = 0;
    edges(12);
    chk(n_wevt, 4);
    chk(n_mevt, 0);
    chk(match_irq, 0);
  endtask
  initial begin
    hresetn = 0;
    hsel = 1;
    htrans = 0;
    haddr = 0;
    hwrite = 0;
    hwdata = 0;
    ref_clk_in = 0;
    match_ack = 0;
    wrap_ack = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    t_reset;
    t_ctrl;
    t_psc;
    t_wrap;
    t_thin;
    end_sim;
  end
endmodule
